// ### design/comm_ldo_rail_control.sv
// Purpose: Control register and regulator steering for the communication rail.
// Assumes: Register port strobes come from the decoded host SPI frame on clk.
// Notes:   Regulator outputs change on the same edge as the register write.
//
// Summary of operation
// - State code 4 off, 5 low power, 6 and 7 active; 0-3 reserved.
// - Standby exit copies exit field into state field only when it holds 4-7.
// - Select code 0 means 1.8 V, 1 means 2.5 V, 2 and 3 reserved.
// - Control register is read/write at 0x4A and resets to 0x24.
// - Second regulator at 1.3 V forces the upstream buck target to 1.6 V.
// - Programmed state and voltage enable the regulator mapped to them.
// - First regulator discharges its output actively while shut down and sibling_first_on is low.
// - Over-current and under-voltage of each regulator raise a status event.
// - Select 1.8 V lets this register drive the second regulator.
// - Select 2.5 V lets this register drive the first regulator.
`timescale 1ns/1ps
`default_nettype none
module comm_ldo_rail_control
    import comm_ldo_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [7:0]         reg_rdata,
    output logic                    reg_rvalid,
    input  wire logic               standby_exit_pin,
    input  wire logic               first_oc_pin,
    input  wire logic               first_uv_pin,
    input  wire logic               second_oc_pin,
    input  wire logic               second_uv_pin,
    input  wire logic               sibling_first_on,
    input  wire logic               sibling_second_13v,
    output logic                    first_ldo_en,
    output logic                    first_ldo_lp,
    output logic                    first_ldo_discharge,
    output logic                    second_ldo_en,
    output logic                    second_ldo_lp,
    output logic                    upstream_buck_1v6,
    output logic      [EVENT_W-1:0] fault_event
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl;
        logic [1:0] sel_eff;
        logic [7:0] rdata;
        logic       rvalid;
        logic       first_en;
        logic       first_lp;
        logic       first_dis;
        logic       second_en;
        logic       second_lp;
        logic       buck_1v6;
    } rail_s;

    localparam rail_s RAIL_RESET = '{
        ctrl:      RAIL_CTRL_RESET,
        sel_eff:   SEL_1V8,
        rdata:     READ_UNMAPPED,
        rvalid:    1'b0,
        first_en:  1'b0,
        first_lp:  1'b0,
        first_dis: 1'b1,
        second_en: 1'b0,
        second_lp: 1'b0,
        buck_1v6:  1'b0
    };

    rail_s            q;
    rail_s            d;
    logic [PIN_W-1:0] pins_rise;
    logic             wr_hit;
    logic             rd_hit;
    logic             exit_rise;
    logic             copy_ok;
    logic [2:0]       next_state;
    logic             state_on;
    logic             state_lp;

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    pin_sync_edge pin_sync_edge_i (
        .clk        (clk),
        .rstn       (rstn),
        .pins_async ({second_uv_pin, second_oc_pin, first_uv_pin, first_oc_pin,
                      standby_exit_pin}),
        .pins_rise  (pins_rise)
    );

    assign exit_rise = pins_rise[PIN_EXIT];
    assign wr_hit    = reg_wr && (reg_addr == RAIL_CTRL_ADDR);
    assign rd_hit    = reg_rd && (reg_addr == RAIL_CTRL_ADDR);
    assign copy_ok   = q.ctrl[EXIT_MSB:EXIT_LSB] >= ST_OFF;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // The exit copy beats a host write to the state field in the same cycle,
    // because the pin event cannot be repeated while the host can retry.
    always_comb begin
        d        = q;
        d.rvalid = 1'b0;
        if (wr_hit) begin
            d.ctrl = reg_wdata;
            if (reg_wdata[SEL_MSB:SEL_LSB] <= SEL_2V5) begin
                d.sel_eff = reg_wdata[SEL_MSB:SEL_LSB];
            end
        end
        if (exit_rise && copy_ok) begin
            d.ctrl[STATE_MSB:STATE_LSB] = q.ctrl[EXIT_MSB:EXIT_LSB];
        end
        if (reg_rd) begin
            d.rvalid = 1'b1;
            if (reg_addr == RAIL_CTRL_ADDR) begin
                d.rdata = q.ctrl;
            end else begin
                d.rdata = READ_UNMAPPED;
            end
        end
        next_state  = d.ctrl[STATE_MSB:STATE_LSB];
        state_on    = (next_state == ST_LP) || (next_state == ST_ACT0) ||
                      (next_state == ST_ACT1);
        state_lp    = (next_state == ST_LP);
        d.first_en  = state_on && (d.sel_eff == SEL_2V5);
        d.first_lp  = state_lp && (d.sel_eff == SEL_2V5);
        d.second_en = state_on && (d.sel_eff == SEL_1V8);
        d.second_lp = state_lp && (d.sel_eff == SEL_1V8);
        d.first_dis = !d.first_en && !sibling_first_on;
        d.buck_1v6  = sibling_second_13v;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= RAIL_RESET;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata           = q.rdata;
    assign reg_rvalid          = q.rvalid;
    assign first_ldo_en        = q.first_en;
    assign first_ldo_lp        = q.first_lp;
    assign first_ldo_discharge = q.first_dis;
    assign second_ldo_en       = q.second_en;
    assign second_ldo_lp       = q.second_lp;
    assign upstream_buck_1v6   = q.buck_1v6;
    assign fault_event         = pins_rise[PIN_SEC_UV:PIN_FIRST_OC];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Firmware keeps the select free of conflicts with the sibling rail, so
    // no check compares the two claims on the second regulator.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_reserved_off;
        (q.ctrl[STATE_MSB:STATE_LSB] < ST_OFF) |-> (!first_ldo_en && !second_ldo_en);
    endproperty
    a_reserved_off: assert property (p_reserved_off) else $error("reserved state enabled");

    property p_low_power;
        (q.ctrl[STATE_MSB:STATE_LSB] == ST_LP) |->
            (first_ldo_lp == first_ldo_en) && (second_ldo_lp == second_ldo_en) &&
            (first_ldo_en != second_ldo_en);
    endproperty
    a_low_power: assert property (p_low_power) else $error("low power decode wrong");

    property p_exit_copy;
        (exit_rise && copy_ok) |=>
            (q.ctrl[STATE_MSB:STATE_LSB] == $past(q.ctrl[EXIT_MSB:EXIT_LSB]));
    endproperty
    a_exit_copy: assert property (p_exit_copy) else $error("exit state not copied");

    property p_exit_nocopy;
        (exit_rise && !copy_ok && !wr_hit) |=>
            $stable(q.ctrl[STATE_MSB:STATE_LSB]);
    endproperty
    a_exit_nocopy: assert property (p_exit_nocopy) else $error("invalid exit copied");

    property p_reset_value;
        $rose(rstn) |-> (q.ctrl == RAIL_CTRL_RESET) && !first_ldo_en && !second_ldo_en;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("bad reset value");

    property p_read_back;
        rd_hit |=> reg_rvalid && (reg_rdata == $past(q.ctrl));
    endproperty
    a_read_back: assert property (p_read_back) else $error("read data wrong");

    property p_write_store;
        (wr_hit && !exit_rise) |=> (q.ctrl == $past(reg_wdata));
    endproperty
    a_write_store: assert property (p_write_store) else $error("write not stored");

    property p_buck;
        sibling_second_13v |=> upstream_buck_1v6;
    endproperty
    a_buck: assert property (p_buck) else $error("buck not raised");

    property p_map_1v8;
        (q.sel_eff == SEL_1V8) |-> !first_ldo_en &&
            (second_ldo_en == (q.ctrl[STATE_MSB:STATE_LSB] >= ST_LP));
    endproperty
    a_map_1v8: assert property (p_map_1v8) else $error("1.8 V mapping wrong");

    property p_map_2v5;
        (q.sel_eff == SEL_2V5) |-> !second_ldo_en &&
            (first_ldo_en == (q.ctrl[STATE_MSB:STATE_LSB] >= ST_LP));
    endproperty
    a_map_2v5: assert property (p_map_2v5) else $error("2.5 V mapping wrong");

    property p_discharge;
        (wr_hit && (reg_wdata[STATE_MSB:STATE_LSB] == ST_OFF) && !exit_rise &&
         !sibling_first_on) |=> first_ldo_discharge && !first_ldo_en;
    endproperty
    a_discharge: assert property (p_discharge) else $error("no discharge when off");

    property p_sel_reserved;
        (wr_hit && (reg_wdata[SEL_MSB:SEL_LSB] > SEL_2V5)) |=> $stable(q.sel_eff);
    endproperty
    a_sel_reserved: assert property (p_sel_reserved) else $error("reserved select used");

    property p_select_valid;
        (wr_hit && (reg_wdata[SEL_MSB:SEL_LSB] <= SEL_2V5)) |=>
            (q.sel_eff == $past(reg_wdata[SEL_MSB:SEL_LSB]));
    endproperty
    a_select_valid: assert property (p_select_valid) else $error("select not taken");

    c_exit_copy: cover property (exit_rise && copy_ok);
    c_first_on:  cover property (wr_hit ##1 first_ldo_en);
    c_read:      cover property (rd_hit ##1 reg_rvalid);
    c_buck:      cover property (upstream_buck_1v6 && second_ldo_en == 1'b0);

endmodule
`default_nettype wire

// ### design/comm_ldo_pkg.sv
// Purpose: Shared constants for the communication rail control block.
// Assumes: One 8-bit control register at one address of the host register port.
// Notes:   Pin index constants order the synchroniser vector.
package comm_ldo_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] RAIL_CTRL_ADDR  = 8'h4a;
    localparam logic [7:0] RAIL_CTRL_RESET = 8'h24;
    localparam logic [7:0] READ_UNMAPPED   = 8'h00;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int STATE_LSB = 0;
    localparam int STATE_MSB = 2;
    localparam int EXIT_LSB  = 3;
    localparam int EXIT_MSB  = 5;
    localparam int SEL_LSB   = 6;
    localparam int SEL_MSB   = 7;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [2:0] ST_OFF  = 3'h4;
    localparam logic [2:0] ST_LP   = 3'h5;
    localparam logic [2:0] ST_ACT0 = 3'h6;
    localparam logic [2:0] ST_ACT1 = 3'h7;
    localparam logic [1:0] SEL_1V8 = 2'h0;
    localparam logic [1:0] SEL_2V5 = 2'h1;

    // ------------------------------------------------------------------
    // Synchronised pin inputs
    // ------------------------------------------------------------------
    localparam int PIN_W        = 5;
    localparam int PIN_EXIT     = 0;
    localparam int PIN_FIRST_OC = 1;
    localparam int PIN_FIRST_UV = 2;
    localparam int PIN_SEC_OC   = 3;
    localparam int PIN_SEC_UV   = 4;
    localparam int EVENT_W      = 4;
    localparam logic [PIN_W-1:0] PINS_IDLE = 5'h00;

endpackage

// ### design/pin_sync_edge.sv
// Purpose: Two-stage synchroniser and rising-edge pulse for the asynchronous pins.
// Assumes: Pins are low while reset is released.
// Notes:   A pin already high at reset release gives one pulse three edges later.
`timescale 1ns/1ps
`default_nettype none
module pin_sync_edge
    import comm_ldo_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [PIN_W-1:0] pins_async,
    output logic      [PIN_W-1:0] pins_rise
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [PIN_W-1:0] meta;
        logic [PIN_W-1:0] sync;
        logic [PIN_W-1:0] prev;
        logic [PIN_W-1:0] rise;
    } sync_s;

    sync_s q;
    sync_s d;

    always_comb begin
        d      = q;
        d.meta = pins_async;
        d.sync = q.meta;
        d.prev = q.sync;
        d.rise = q.sync & ~q.prev;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '{meta: PINS_IDLE, sync: PINS_IDLE, prev: PINS_IDLE, rise: PINS_IDLE};
        end else begin
            q <= d;
        end
    end

    assign pins_rise = q.rise;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Checked against the raw pins, so a broken stage or a lost edge shows up.
    // The first four edges after reset are skipped while the flops fill.
    property p_edge_pulse;
        @(posedge clk) disable iff (!rstn)
        $past(rstn, 4) |-> (pins_rise == ($past(pins_async, 3) & ~$past(pins_async, 4)));
    endproperty
    a_edge_pulse: assert property (p_edge_pulse) else $error("pin edge pulse missing");

endmodule
`default_nettype wire

// ### dv/spi_host_model.sv
// Purpose: Host side of the decoded register port, issuing strobed writes and reads.
// Assumes: Callers enter each task just after a rising edge of clk.
// Notes:   Write data is inverted after use so stale data never looks valid.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input  wire logic       clk,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    // ------------------------------------------------------------
    // Host transfers
    // ------------------------------------------------------------
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // A missing answer returns unknown data so the caller's compare fails.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        for (n = 0; n < 4; n++) begin
            @(negedge clk);
            if (reg_rvalid === 1'b1) break;
        end
        d = (n < 4) ? reg_rdata : 8'hxx;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ### dv/comm_ldo_rail_control_test.sv
// Purpose: Self-checking bench for the communication rail control block.
// Assumes: Sibling rail inputs never claim the second regulator at 1.3 V with 1.8 V here.
// Notes:   Expected outputs come from a bench-side mirror of the register.
`timescale 1ns/1ps
`default_nettype none
module comm_ldo_rail_control_test
    import comm_ldo_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, mirror, rd_val, wd;
    logic       reg_wr, reg_rd, reg_rvalid;
    logic       exit_pin = 1'b0;
    logic [3:0] flt = 4'h0;
    logic       sib_first = 1'b0;
    logic       sib_13 = 1'b0;
    logic [5:0] outs;
    logic [3:0] fault_event;
    logic [1:0] sel_last, nsel;
    int         seed = 22;
    int         checks = 0;
    int         failures = 0;
    int         cnt;

    always #25 clk = ~clk;

    spi_host_model spi_host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    comm_ldo_rail_control comm_ldo_rail_control_i (.clk(clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .standby_exit_pin(exit_pin),
        .first_oc_pin(flt[0]), .first_uv_pin(flt[1]), .second_oc_pin(flt[2]),
        .second_uv_pin(flt[3]), .sibling_first_on(sib_first), .sibling_second_13v(sib_13),
        .first_ldo_en(outs[5]), .first_ldo_lp(outs[4]), .first_ldo_discharge(outs[3]),
        .second_ldo_en(outs[2]), .second_ldo_lp(outs[1]), .upstream_buck_1v6(outs[0]),
        .fault_event(fault_event));

    // ------------------------------------------------------------
    // Expectations and compares
    // ------------------------------------------------------------
    function automatic logic [5:0] exp_outs(input logic [7:0] r, input logic [1:0] sl);
        logic on, lp, fe, se;
        on = r[2:0] inside {ST_LP, ST_ACT0, ST_ACT1};
        lp = (r[2:0] == ST_LP);
        fe = on && (sl == SEL_2V5);
        se = on && (sl == SEL_1V8);
        return {fe, fe && lp, !fe && !sib_first, se, se && lp, sib_13};
    endfunction

    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_outs();
        @(negedge clk);
        checks++;
        if (outs !== exp_outs(mirror, sel_last)) begin
            failures++;
            $display("[FAIL] regulator outputs expected %b seen %b",
                     exp_outs(mirror, sel_last), outs);
        end
        @(posedge clk);
    endtask

    task automatic put(input logic [7:0] d);
        spi_host_model_i.wr(RAIL_CTRL_ADDR, d);
        mirror = d;
        if (d[7:6] inside {SEL_1V8, SEL_2V5}) sel_last = d[7:6];
        @(posedge clk);
        chk_outs();
        spi_host_model_i.rd(RAIL_CTRL_ADDR, rd_val);
        chk_byte("rail register", mirror, rd_val);
    endtask

    task automatic close_out();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        mirror   = RAIL_CTRL_RESET;
        sel_last = SEL_1V8;
        chk_outs();
        spi_host_model_i.rd(RAIL_CTRL_ADDR, rd_val);
        chk_byte("reset value", RAIL_CTRL_RESET, rd_val);
        put({SEL_1V8, ST_OFF, ST_OFF});
        for (int i = 0; i < 32; i++) put({i[4:3], ST_OFF, i[2:0]});
        for (int e = 0; e < 8; e++) begin
            put({1'b0, e[0], e[2:0], ST_LP});
            exit_pin <= 1'b1;
            repeat (3) @(posedge clk);
            exit_pin <= 1'b0;
            repeat (4) @(posedge clk);
            if (e >= 4) mirror[2:0] = e[2:0];
            chk_outs();
            spi_host_model_i.rd(RAIL_CTRL_ADDR, rd_val);
            chk_byte("state after exit", mirror, rd_val);
        end
        spi_host_model_i.wr(8'h4b, 8'hff);
        spi_host_model_i.rd(8'h4b, rd_val);
        chk_byte("unmapped read", READ_UNMAPPED, rd_val);
        spi_host_model_i.rd(RAIL_CTRL_ADDR, rd_val);
        chk_byte("after unmapped write", mirror, rd_val);
        for (int k = 0; k < 4; k++) begin
            flt <= 4'h1 << k;
            cnt = 0;
            repeat (8) begin
                @(negedge clk);
                if (fault_event === (4'h1 << k)) cnt++;
                else if (fault_event !== 4'h0) cnt += 10;
            end
            @(posedge clk);
            flt <= 4'h0;
            repeat (3) @(posedge clk);
            chk_byte("fault pulse count", 8'h01, cnt[7:0]);
        end
        // Sibling never takes the second regulator while this rail selects 1.8 V.
        for (int n = 0; n < 40; n++) begin
            wd = 8'($random(seed));
            nsel = (wd[7:6] inside {SEL_1V8, SEL_2V5}) ? wd[7:6] : sel_last;
            sib_first <= 1'($random(seed));
            sib_13 <= (nsel != SEL_1V8) && 1'($random(seed));
            put(wd);
        end
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
